// [verilog/lss_pkg.sv]
// Shared constants, types and helpers of the level and setpoint supervision block.
// Assumes a single 125 MHz clock and signed force words from the measurement chain.
package lss_pkg;

  // Force word width and block dimensions.
  localparam int FW   = 24;
  localparam int NLVL = 8;
  localparam int NSP  = 2;
  localparam int NOUT = 18;
  localparam int OSW  = 5;

  // Output select value that routes nowhere; any code at or above NOUT does the same.
  localparam logic [OSW-1:0] OUT_NONE = 5'h1f;

  // Clock rate and the 0.1 ms unit that divides the filter time into ten updates.
  localparam int CLK_HZ       = 125_000_000;
  localparam int TICK_UNIT_US = 100;
  localparam int CYC_PER_UNIT = CLK_HZ / 1_000_000 * TICK_UNIT_US;
  localparam logic [15:0] FILT_MS_DEF = 16'h00c8;

  // Register byte offsets on the bus.
  localparam logic [7:0] ADR_CMD    = 8'h00;
  localparam logic [7:0] ADR_COIL   = 8'h04;
  localparam logic [7:0] ADR_SPVAL  = 8'h08;
  localparam logic [7:0] ADR_STAT2  = 8'h10;
  localparam logic [7:0] ADR_LSTAT  = 8'h14;
  localparam logic [7:0] ADR_SPCFG  = 8'h18;
  localparam logic [7:0] ADR_FILT   = 8'h1c;
  localparam logic [7:0] ADR_LVAL   = 8'h20;
  localparam logic [7:0] ADR_LCFG   = 8'h40;
  localparam logic [7:0] ADR_LHYST  = 8'h60;
  localparam logic [7:0] ADR_END    = 8'h80;

  // Field positions in the level and setpoint configuration words.
  localparam int CFG_SRC_LSB   = 0;
  localparam int CFG_BELOW_BIT = 4;
  localparam int CFG_OUT_LSB   = 8;
  localparam int SPCFG_STRIDE  = 8;
  localparam int SPCFG_OUT_LSB = 16;

  // Status 2 bit positions.
  localparam int ST2_ACT_LSB  = 0;
  localparam int ST2_DONE_LSB = 2;
  localparam int ST2_ZTHOLD   = 4;

  // Command numbers.
  localparam logic [15:0] CMD_ARM1  = 16'h0001;
  localparam logic [15:0] CMD_DIS1  = 16'h0002;
  localparam logic [15:0] CMD_ARM2  = 16'h0003;
  localparam logic [15:0] CMD_DIS2  = 16'h0004;
  localparam logic [15:0] CMD_ARMB  = 16'h0005;
  localparam logic [15:0] CMD_DISB  = 16'h0006;
  localparam int NCMD = 6;

  // Source of a level or setpoint.
  typedef enum logic [2:0] {
    SRC_OFF, SRC_REL, SRC_ABS, SRC_DISP, SRC_MREL, SRC_MABS, SRC_MDISP, SRC_OFFS
  } lss_src_e;

  typedef logic signed [FW-1:0] lss_force_t;
  typedef logic signed [FW+1:0] lss_wide_t;

  // Level configuration word.
  typedef struct packed {
    logic [OSW-1:0] out_sel;
    logic           below;
    lss_src_e       src;
  } lss_lcfg_s;

  // Force sample captured at an update tick.
  typedef struct packed {
    lss_force_t abs_f;
    lss_force_t rel_f;
    logic       disp_rel;
  } lss_frc_s;

  // Picks the supervised signal for a source, widened so magnitudes never overflow.
  function automatic lss_wide_t lss_pick(input lss_src_e src, input lss_frc_s f);
    lss_wide_t r;
    lss_wide_t a;
    lss_wide_t d;
    r = '0;
    a = lss_wide_t'(f.abs_f);
    d = f.disp_rel ? lss_wide_t'(f.rel_f) : a;
    unique case (src)
      SRC_REL:   r = lss_wide_t'(f.rel_f);
      SRC_ABS:   r = a;
      SRC_DISP:  r = d;
      SRC_MREL:  r = (f.rel_f < 0) ? -lss_wide_t'(f.rel_f) : lss_wide_t'(f.rel_f);
      SRC_MABS:  r = (a < 0) ? -a : a;
      SRC_MDISP: r = (d < 0) ? -d : d;
      SRC_OFF, SRC_OFFS: r = '0;
    endcase
    return r;
  endfunction

endpackage

// [verilog/lss_level.sv]
// One level comparator: source choice, offset mode, signed hysteresis, output sense.
// Assumes the caller holds the above state and hands in the level one settings.
`timescale 1ns/1ps
module lss_level import lss_pkg::*; (
  input  wire lss_lcfg_s  cfg_i,     // Own configuration.
  input  wire lss_force_t val_i,     // Own level value.
  input  wire lss_force_t hyst_i,    // Own signed hysteresis width.
  input  wire lss_src_e   src1_i,    // Level one source, used in offset mode.
  input  wire lss_force_t val1_i,    // Level one value, used in offset mode.
  input  wire logic       offs_ok_i, // High where offset mode is allowed.
  input  wire lss_frc_s   frc_i,     // Newly produced force sample.
  input  wire logic       above_i,   // Present above state.
  output logic            above_o,   // Above state after this update.
  output logic            out_o      // Output drive wish after this update.
);

  lss_src_e  src;   // Effective source.
  lss_wide_t thr;   // Effective threshold.
  lss_wide_t sig;   // Supervised signal.
  lss_wide_t up;    // Switch point for a rising signal.
  lss_wide_t dn;    // Switch point for a falling signal.
  logic      used;  // Level is in use.

  // Work out the switch points and the new above state.
  always_comb begin
    src = cfg_i.src;
    thr = lss_wide_t'(val_i);
    if (cfg_i.src == SRC_OFFS && offs_ok_i) begin
      src = src1_i;
      thr = lss_wide_t'(val1_i) + lss_wide_t'(val_i);
    end
    used = (src != SRC_OFF) && (src != SRC_OFFS);
    sig = lss_pick(src, frc_i);
    if (hyst_i < 0) begin
      up = thr;
      dn = thr + lss_wide_t'(hyst_i);
    end else begin
      up = thr + lss_wide_t'(hyst_i);
      dn = thr;
    end
    if (!used) begin
      above_o = 1'b0;
    end else if (above_i) begin
      above_o = !(sig < dn);
    end else begin
      above_o = (sig > up);
    end
    out_o = used && (above_o ^ cfg_i.below);
  end

endmodule // lss_level

// [verilog/lss_setpoint.sv]
// One one-shot setpoint: armed by command, disarmed by command or when the force passes it.
// Assumes one-cycle arm, disarm and load pulses and a one-cycle update tick.
`timescale 1ns/1ps
module lss_setpoint import lss_pkg::*; (
  input  wire logic       clk_i,     // System clock.
  input  wire logic       rst_i,     // Synchronous reset, active high.
  input  wire logic       tick_i,    // Force update tick.
  input  wire lss_src_e   src_i,     // Source choice.
  input  wire lss_force_t val_i,     // Loaded setpoint value.
  input  wire lss_frc_s   frc_i,     // Newly produced force sample.
  input  wire logic       arm_i,     // Arm pulse.
  input  wire logic       disarm_i,  // Disarm pulse.
  input  wire logic       load_i,    // Value written pulse.
  output logic            active_o,  // Setpoint armed.
  output logic            done_o     // Cycle done flag.
);

  typedef struct packed {
    logic active;
    logic done;
  } lss_sp_s;

  lss_sp_s   st;       // Registered state.
  lss_sp_s   next_st;  // Next state.
  logic      trip;     // Force passes the armed setpoint on this tick.

  // Next state; the hardware trip is applied last so its set beats any clear.
  always_comb begin
    next_st = st;
    trip = tick_i && st.active && (src_i != SRC_OFF) && (src_i != SRC_OFFS) &&
           (lss_pick(src_i, frc_i) > lss_wide_t'(val_i));
    if (load_i) begin
      next_st.done = 1'b0;
    end
    if (disarm_i) begin
      next_st.active = 1'b0;
    end
    if (arm_i) begin
      next_st.active = 1'b1;
      next_st.done   = 1'b0;
    end
    if (trip) begin
      next_st.active = 1'b0;
      next_st.done   = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active_o = st.active;
  assign done_o   = st.done;

endmodule // lss_setpoint

// [verilog/lss_top.sv]
// Level and setpoint supervision with a classic Wishbone register slave.
// Assumes force words are stable whenever the internal update tick fires.
`timescale 1ns/1ps
module lss_top import lss_pkg::*; #(
  parameter int CYC_UNIT = CYC_PER_UNIT  // Clock cycles in 0.1 ms.
) (
  input  wire logic             clk_i,        // System clock, 125 MHz.
  input  wire logic             rst_i,        // Synchronous reset, active high.
  input  wire logic             wb_cyc_i,     // Wishbone cycle.
  input  wire logic             wb_stb_i,     // Wishbone strobe.
  input  wire logic             wb_we_i,      // Wishbone write enable.
  input  wire logic [7:0]       wb_adr_i,     // Wishbone byte address.
  input  wire logic [3:0]       wb_sel_i,     // Wishbone byte lanes.
  input  wire logic [31:0]      wb_dat_i,     // Wishbone write data.
  output logic      [31:0]      wb_dat_o,     // Wishbone read data.
  output logic                  wb_ack_o,     // Wishbone acknowledge.
  input  wire lss_force_t       abs_force_i,  // Absolute force.
  input  wire lss_force_t       rel_force_i,  // Relative force.
  input  wire logic             disp_rel_i,   // High while relative force is displayed.
  output logic [NOUT-1:0]       dout_o,       // Digital outputs 01,02,11-18,21-28.
  output logic                  zt_hold_o,    // Zero tracking suspended.
  output logic                  tick_o        // Internal force update tick.
);

  typedef struct packed {
    logic                       ack;
    logic [31:0]                rdat;
    logic [31:0]                pre;
    logic [15:0]                tenth;
    logic [15:0]                filt_ms;
    logic                       tick;
    lss_frc_s                   frc;
    logic [NLVL-1:0][FW-1:0]    lval;
    logic [NLVL-1:0][FW-1:0]    lhyst;
    lss_lcfg_s [NLVL-1:0]       lcfg;
    logic [NLVL-1:0]            above;
    logic [NSP-1:0][FW-1:0]     spval;
    lss_src_e [NSP-1:0]         spsrc;
    logic [NSP-1:0][OSW-1:0]    spout;
    logic [NOUT-1:0]            dout;
    logic                       zt;
  } lss_top_s;

  lss_top_s        st;         // Registered state.
  lss_top_s        next_st;    // Next state.
  logic [NLVL-1:0] lv_above;   // Comparator results for this tick.
  logic [NLVL-1:0] lv_act;     // Registered output wishes.
  logic [NSP-1:0]  sp_act;     // Setpoints armed.
  logic [NSP-1:0]  sp_done;    // Setpoint cycle done flags.
  logic [NSP-1:0]  sp_arm;     // Arm pulses.
  logic [NSP-1:0]  sp_dis;     // Disarm pulses.
  logic [NSP-1:0]  sp_load;    // Value load pulses.
  logic            req;        // New bus request this cycle.
  logic            wr;         // New bus write this cycle.
  logic [NCMD:1]   cmd;        // Commands issued this cycle.
  logic [31:0]     wmask;      // Byte lane mask.
  logic [2:0]      idx;        // Register index within an array.

  // Merges write data into an old value under the byte lane mask.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    return (old & ~m) | (d & m);
  endfunction

  for (genvar i = 0; i < NLVL; i++) begin : g_lvl
    lss_level u_lvl (
      .cfg_i     (st.lcfg[i]),
      .val_i     (lss_force_t'(st.lval[i])),
      .hyst_i    (lss_force_t'(st.lhyst[i])),
      .src1_i    (st.lcfg[0].src),
      .val1_i    (lss_force_t'(st.lval[0])),
      .offs_ok_i (i != 0),
      .frc_i     (st.frc),
      .above_i   (st.above[i]),
      .above_o   (lv_above[i]),
      .out_o     ()
    );
    // Output wish from the held state; an offset level behind an unused level one stays off.
    assign lv_act[i] = (st.lcfg[i].src != SRC_OFF) &&
                       (st.lcfg[i].src != SRC_OFFS || (i != 0 && st.lcfg[0].src != SRC_OFF &&
                                                       st.lcfg[0].src != SRC_OFFS)) &&
                       (st.above[i] ^ st.lcfg[i].below);
  end

  for (genvar s = 0; s < NSP; s++) begin : g_sp
    lss_setpoint u_sp (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .tick_i   (st.tick),
      .src_i    (st.spsrc[s]),
      .val_i    (lss_force_t'(st.spval[s])),
      .frc_i    (st.frc),
      .arm_i    (sp_arm[s]),
      .disarm_i (sp_dis[s]),
      .load_i   (sp_load[s]),
      .active_o (sp_act[s]),
      .done_o   (sp_done[s])
    );
  end

  // Bus decode, command decode, tick divider and output routing.
  always_comb begin
    next_st = st;
    req     = wb_cyc_i && wb_stb_i && !st.ack;
    wr      = req && wb_we_i;
    idx     = wb_adr_i[4:2];
    wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    cmd     = '0;
    sp_load = '0;
    // Acknowledge every request one cycle later, mapped or not.
    next_st.ack  = req;
    next_st.rdat = '0;
    if (wr && wb_adr_i == ADR_CMD && wb_sel_i[0]) begin
      for (int c = 1; c <= NCMD; c++) begin
        cmd[c] = (wb_dat_i[15:0] == 16'(c)) && (wb_sel_i[1] || wb_dat_i[15:8] == 8'h00);
      end
    end
    if (wr && wb_adr_i == ADR_COIL && wb_sel_i[0]) begin
      cmd = cmd | wb_dat_i[NCMD-1:0];
    end
    sp_arm[0] = cmd[CMD_ARM1] || cmd[CMD_ARMB];
    sp_arm[1] = cmd[CMD_ARM2] || cmd[CMD_ARMB];
    sp_dis[0] = cmd[CMD_DIS1] || cmd[CMD_DISB];
    sp_dis[1] = cmd[CMD_DIS2] || cmd[CMD_DISB];
    if (wr) begin
      if (wb_adr_i == ADR_SPVAL || wb_adr_i == ADR_SPVAL + 8'h04) begin
        next_st.spval[wb_adr_i[2]] = FW'(merge(32'(signed'(st.spval[wb_adr_i[2]])), wmask, wb_dat_i));
        sp_load[wb_adr_i[2]] = 1'b1;
      end
      if (wb_adr_i == ADR_SPCFG) begin
        for (int s = 0; s < NSP; s++) begin
          if (wb_sel_i[s]) begin
            next_st.spsrc[s] = lss_src_e'(wb_dat_i[s*SPCFG_STRIDE +: 3]);
          end
          if (wb_sel_i[2 + s]) begin
            next_st.spout[s] = wb_dat_i[SPCFG_OUT_LSB + s*SPCFG_STRIDE +: OSW];
          end
        end
      end
      if (wb_adr_i == ADR_FILT) begin
        next_st.filt_ms = 16'(merge(32'(st.filt_ms), wmask, wb_dat_i));
      end
      if (wb_adr_i >= ADR_LVAL && wb_adr_i < ADR_LCFG) begin
        next_st.lval[idx] = FW'(merge(32'(signed'(st.lval[idx])), wmask, wb_dat_i));
      end
      if (wb_adr_i >= ADR_LCFG && wb_adr_i < ADR_LHYST) begin
        if (wb_sel_i[0]) begin
          next_st.lcfg[idx].src   = lss_src_e'(wb_dat_i[CFG_SRC_LSB +: 3]);
          next_st.lcfg[idx].below = wb_dat_i[CFG_BELOW_BIT];
        end
        if (wb_sel_i[1]) begin
          next_st.lcfg[idx].out_sel = wb_dat_i[CFG_OUT_LSB +: OSW];
        end
      end
      if (wb_adr_i >= ADR_LHYST && wb_adr_i < ADR_END) begin
        next_st.lhyst[idx] = FW'(merge(32'(signed'(st.lhyst[idx])), wmask, wb_dat_i));
      end
    end
    // Read data, registered; unmapped addresses read zero.
    if (req && !wb_we_i) begin
      if (wb_adr_i == ADR_SPVAL || wb_adr_i == ADR_SPVAL + 8'h04) begin
        next_st.rdat = 32'(signed'(st.spval[wb_adr_i[2]]));
      end
      if (wb_adr_i == ADR_STAT2) begin
        next_st.rdat[ST2_ACT_LSB +: NSP]  = sp_act;
        next_st.rdat[ST2_DONE_LSB +: NSP] = sp_done;
        next_st.rdat[ST2_ZTHOLD]          = st.zt;
      end
      if (wb_adr_i == ADR_LSTAT) begin
        next_st.rdat[NLVL-1:0] = st.above;
      end
      if (wb_adr_i == ADR_SPCFG) begin
        for (int s = 0; s < NSP; s++) begin
          next_st.rdat[s*SPCFG_STRIDE +: 3]                = st.spsrc[s];
          next_st.rdat[SPCFG_OUT_LSB + s*SPCFG_STRIDE +: OSW] = st.spout[s];
        end
      end
      if (wb_adr_i == ADR_FILT) begin
        next_st.rdat = 32'(st.filt_ms);
      end
      if (wb_adr_i >= ADR_LVAL && wb_adr_i < ADR_LCFG) begin
        next_st.rdat = 32'(signed'(st.lval[idx]));
      end
      if (wb_adr_i >= ADR_LCFG && wb_adr_i < ADR_LHYST) begin
        next_st.rdat[CFG_SRC_LSB +: 3]     = st.lcfg[idx].src;
        next_st.rdat[CFG_BELOW_BIT]        = st.lcfg[idx].below;
        next_st.rdat[CFG_OUT_LSB +: OSW]   = st.lcfg[idx].out_sel;
      end
      if (wb_adr_i >= ADR_LHYST && wb_adr_i < ADR_END) begin
        next_st.rdat = 32'(signed'(st.lhyst[idx]));
      end
    end
    // ten updates per filter time: one tick per filter_ms units of 0.1 ms
    next_st.tick = 1'b0;
    if (st.pre >= 32'(CYC_UNIT - 1)) begin
      next_st.pre = '0;
      if (st.tenth + 16'h0001 >= st.filt_ms) begin
        next_st.tenth = '0;
        next_st.tick  = 1'b1;
      end else begin
        next_st.tenth = st.tenth + 16'h0001;
      end
    end else begin
      next_st.pre = st.pre + 32'h0000_0001;
    end
    // Capture the new force sample on the tick; comparisons use it the cycle after.
    if (next_st.tick) begin
      next_st.frc = '{abs_f: abs_force_i, rel_f: rel_force_i, disp_rel: disp_rel_i};
    end
    if (st.tick) begin
      next_st.above = lv_above;
    end
    next_st.zt = |sp_act;
    // route levels and setpoints to outputs
    next_st.dout = '0;
    for (int o = 0; o < NOUT; o++) begin
      for (int i = 0; i < NLVL; i++) begin
        if (st.lcfg[i].out_sel == OSW'(o) && lv_act[i]) begin
          next_st.dout[o] = 1'b1;
        end
      end
      for (int s = 0; s < NSP; s++) begin
        if (st.spout[s] == OSW'(o) && sp_act[s]) begin
          next_st.dout[o] = 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= '0;
      st.filt_ms <= FILT_MS_DEF;
      st.spout   <= {NSP{OUT_NONE}};
      for (int i = 0; i < NLVL; i++) begin
        st.lcfg[i].out_sel <= OUT_NONE;
      end
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o  = st.rdat;
  assign wb_ack_o  = st.ack;
  assign dout_o    = st.dout;
  assign zt_hold_o = st.zt;
  assign tick_o    = st.tick;

endmodule // lss_top

// [test/lss_asserts.sv]
// Port checker for the level and setpoint supervision top.
// Assumes it is bound to lss_top and sees only that module's ports.
`timescale 1ns/1ps
module lss_chk import lss_pkg::*; #(
  parameter int CYC_UNIT = 4  // Clock cycles in one tick unit.
) (
  input  wire logic            clk_i,     // System clock.
  input  wire logic            rst_i,     // Synchronous reset.
  input  wire logic            wb_cyc_i,  // Bus cycle.
  input  wire logic            wb_stb_i,  // Bus strobe.
  input  wire logic            wb_ack_o,  // Bus acknowledge.
  input  wire logic [NOUT-1:0] dout_o,    // Digital outputs.
  input  wire logic            zt_hold_o, // Zero tracking suspended.
  input  wire logic            tick_o     // Force update tick.
);
  int   since;  // Cycles since the last tick.
  logic seen;   // A tick passed with no bus answer since.

  // Bus answers are excluded because a filter write may cut the present tick gap short.
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_o) since <= 0;
    else since <= since + 1;
    if (rst_i || wb_ack_o) seen <= 1'b0;
    else if (tick_o) seen <= 1'b1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_tick_pulse: assert property (tick_o |=> !tick_o)
    else $error("tick longer than one cycle");
  a_tick_space: assert property (tick_o && seen |-> since >= CYC_UNIT - 1)
    else $error("ticks too close");
  a_zt_rise: assert property ($rose(zt_hold_o) |-> $past(wb_ack_o))
    else $error("zero hold rose without command");
  a_zt_fall: assert property ($fell(zt_hold_o) |-> $past(wb_ack_o) || $past(tick_o, 2) || $past(tick_o, 3))
    else $error("zero hold fell without cause");
  a_dout_cause: assert property ($changed(dout_o) |-> $past(wb_ack_o) || $past(tick_o, 2) || $past(tick_o, 3))
    else $error("outputs changed without cause");
  a_rst_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !tick_o && !zt_hold_o && dout_o == '0)
    else $error("outputs not quiet after reset");

  c_arm: cover property ($rose(zt_hold_o));
  c_trip: cover property ($fell(zt_hold_o) && $past(tick_o, 2));
  c_dout: cover property ($changed(dout_o));
endmodule // lss_chk

bind lss_top lss_chk #(.CYC_UNIT(CYC_UNIT)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dout_o(dout_o), .zt_hold_o(zt_hold_o), .tick_o(tick_o));

// [test/lss_host.sv]
// Model of the serial master that loads setpoints and issues commands.
// Assumes a classic Wishbone slave that acknowledges every request.
`timescale 1ns/1ps
module lss_host import lss_pkg::*; (
  input  wire logic        clk_i,  // System clock.
  input  wire logic        ack_i,  // Slave acknowledge.
  input  wire logic [31:0] dat_i,  // Read data.
  output logic             cyc_o,  // Bus cycle.
  output logic             stb_o,  // Bus strobe.
  output logic             we_o,   // Write enable.
  output logic [7:0]       adr_o,  // Byte address.
  output logic [3:0]       sel_o,  // Byte lanes.
  output logic [31:0]      dat_o   // Write data.
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // One classic cycle; released address and data lines show the inverse so stale data never matches.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask

  task automatic cmd(input int c, input bit coil);
    logic [31:0] q;
    if (coil) xfer(1'b1, ADR_COIL, 32'h1 << (c - 1), q);
    else xfer(1'b1, ADR_CMD, 32'(c), q);
  endtask

  task automatic spval(input int n, input int v);
    logic [31:0] q;
    xfer(1'b1, ADR_SPVAL + 8'(4 * n), 32'(v), q);
  endtask
endmodule // lss_host

// [test/tb_top.sv]
// Self-checking bench for the level and setpoint supervision block.
// Assumes the block is built with a four-cycle tick unit.
`timescale 1ns/1ps
module tb_top import lss_pkg::*; ;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            cyc, stb, we, ack, disp_rel, zt, tick;
  logic [7:0]      adr;
  logic [3:0]      sel;
  logic [31:0]     wdat, rdat, q;
  lss_force_t      abs_f, rel_f;
  logic [NOUT-1:0] dout;
  int              mismatches, n_tests, fa, fr, lsrc[8], lval[8], lhy[8];
  bit              fd, lbel[8], lab[8];
  logic [1:0]      arm, done;

  always #4 clk_i = ~clk_i;

  lss_top #(.CYC_UNIT(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .abs_force_i(abs_f),
    .rel_force_i(rel_f), .disp_rel_i(disp_rel), .dout_o(dout), .zt_hold_o(zt), .tick_o(tick));
  lss_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat));

  function automatic int rnd(int n);
    return int'($urandom % (2 * n + 1)) - n;
  endfunction
  // Supervised signal of a source code for the present forces.
  function automatic longint sig(int s);
    longint a, r, d;
    a = fa;
    r = fr;
    d = fd ? r : a;
    case (s)
      1: return r;
      2: return a;
      3: return d;
      4: return r < 0 ? -r : r;
      5: return a < 0 ? -a : a;
      6: return d < 0 ? -d : d;
      default: return 0;
    endcase
  endfunction
  // Next above state with the signed hysteresis band.
  function automatic bit upd(bit ab, longint s, longint t, longint h);
    if (!ab) return s > (h > 0 ? t + h : t);
    return !(s < (h < 0 ? t + h : t));
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic setf(input int a, input int r, input bit d);
    @(posedge clk_i);
    fa = a;
    fr = r;
    fd = d;
    abs_f <= lss_force_t'(a);
    rel_f <= lss_force_t'(r);
    disp_rel <= d;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      do @(posedge clk_i); while (tick !== 1'b1);
    end
    repeat (3) @(posedge clk_i);
  endtask
  // Sets the filter time, reads it back and measures one full tick period.
  task automatic tick_gap(input int f);
    int n;
    host.xfer(1'b1, ADR_FILT, 32'(f), q);
    host.xfer(1'b0, ADR_FILT, 32'h0, q);
    chk("filter time", 32'(f), q);
    do @(posedge clk_i); while (tick !== 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1);
    chk("tick gap", 32'(4 * f), 32'(n));
  endtask
  task automatic lvl_check();
    logic [7:0] st, od;
    for (int i = 0; i < 8; i++) begin
      lab[i] = lsrc[i] != 0 && upd(lab[i], sig(lsrc[i] == 7 ? lsrc[0] : lsrc[i]),
                                   lsrc[i] == 7 ? lval[0] + lval[i] : lval[i], lhy[i]);
      st[i] = lab[i];
      od[i] = lab[i] ^ lbel[i] && lsrc[i] != 0;
    end
    host.xfer(1'b0, ADR_LSTAT, 32'h0, q);
    chk("level status", {24'h0, st}, q);
    chk("level outputs", {22'h0, od, 2'b00}, 32'(dout));
  endtask
  task automatic sp_check();
    repeat (2) @(posedge clk_i);
    host.xfer(1'b0, ADR_STAT2, 32'h0, q);
    chk("status2", {27'h0, |arm, done, arm}, q);
    chk("sp outputs", {14'h0, 16'h0, arm}, 32'(dout));
    chk("zero hold", 32'(|arm), 32'(zt));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    mismatches++;
    end_of_test();
  end

  initial begin
    abs_f = '0;
    rel_f = '0;
    disp_rel = 1'b0;
    void'($urandom(2));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    tick_gap(3);
    tick_gap(1);
    host.xfer(1'b0, ADR_END, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    $display("test registers done");
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 8; i++) begin
        lsrc[i] = i == 0 ? 1 + $urandom % 6 : $urandom % 8;
        lval[i] = rnd(1000);
        lhy[i] = rnd(300);
        lbel[i] = $urandom % 2;
        host.xfer(1'b1, ADR_LVAL + 8'(4 * i), 32'(lval[i]), q);
        host.xfer(1'b1, ADR_LHYST + 8'(4 * i), 32'(lhy[i]), q);
        host.xfer(1'b1, ADR_LCFG + 8'(4 * i), {19'h0, 5'(i + 2), 3'h0, lbel[i], 1'b0, 3'(lsrc[i])}, q);
      end
      setf(8000, 8000, c[0]);
      ticks(2);
      lvl_check();
      for (int k = 0; k < 12; k++) begin
        setf(k == 0 ? lval[0] : rnd(1200), k == 0 ? lval[0] : rnd(1200), $urandom % 2);
        ticks(2);
        lvl_check();
      end
    end
    for (int i = 0; i < 8; i++) begin
      lsrc[i] = 0;
      // Offset mode everywhere, level one included, leaves every level unused and its output off.
      host.xfer(1'b1, ADR_LCFG + 8'(4 * i), {19'h0, 5'(i + 2), 8'h17}, q);
    end
    ticks(2);
    lvl_check();
    $display("test levels done");
    host.xfer(1'b1, ADR_SPCFG, 32'h0100_0102, q);
    setf(0, 0, 1'b0);
    host.spval(0, 500);
    host.spval(1, 500);
    arm = 2'b00;
    done = 2'b00;
    for (int p = 0; p < 2; p++) begin
      for (int c = 1; c <= 6; c++) begin
        host.cmd(c, p[0]);
        arm = c == 5 ? 2'b11 : c == 6 ? 2'b00 : c % 2 ? arm | 2'(1 << (c / 2)) : arm & ~2'(1 << ((c - 1) / 2));
        sp_check();
      end
    end
    host.cmd(5, 1'b0);
    arm = 2'b11;
    setf(500, 0, 1'b0);
    ticks(3);
    sp_check();
    setf(501, 0, 1'b0);
    ticks(3);
    arm = 2'b10;
    done = 2'b01;
    sp_check();
    host.spval(0, 700);
    done = 2'b00;
    sp_check();
    setf(0, 900, 1'b0);
    ticks(3);
    arm = 2'b00;
    done = 2'b10;
    sp_check();
    setf(0, 0, 1'b0);
    host.cmd(3, 1'b1);
    arm = 2'b10;
    done = 2'b00;
    sp_check();
    host.cmd(4, 1'b0);
    arm = 2'b00;
    sp_check();
    $display("test setpoints done");
    end_of_test();
  end
endmodule // tb_top
